/* File: rtl/tss_strap_sampler.sv */
// test strap sampler: pin tri-state, strap capture, test output drive
//
// Notes on behaviour
// - while power-on reset is low, all test pins are undriven
// - about 1.5 us after reset rises, each pin level is captured
// - after capture, every test pin is driven as output until reset
// - captured pins zero, one, two form mode select bits 0, 1, 2
// - each pin has a weak pull-down, so open pins sample low
// - self-configuration starts on rising edge of power-on reset
`timescale 1ns/100ps
module tss_strap_sampler #(
    parameter int unsigned SAMPLE_CYCLES = tss_pkg::TSS_SAMPLE_CYCLES
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_srst,
    // power-on reset pin, active low, synchronous to i_clk
    input wire logic i_power_on_reset_low,
    // test pins: level seen at pad, and whether the board drives it
    input wire logic [tss_pkg::TSS_PIN_COUNT-1:0] i_test_strap_pin,
    input wire logic [tss_pkg::TSS_PIN_COUNT-1:0] i_test_strap_pin_driven,
    output logic [tss_pkg::TSS_PIN_COUNT-1:0] o_test_strap_pin,
    output logic [tss_pkg::TSS_PIN_COUNT-1:0] o_test_strap_pin_oe,
    // test output data from the core
    input wire logic [tss_pkg::TSS_PIN_COUNT-1:0] i_test_out,
    // captured mode
    output logic [tss_pkg::TSS_MODE_WIDTH-1:0] o_test_mode_select,
    output logic o_test_mode_active,
    output logic o_config_start,
    output logic o_strap_done
);
    import tss_pkg::*;

    // ************************************************************
    // decoding
    // ************************************************************
    // the mode code is read in two places; one decode keeps them in step
    function automatic logic [TSS_MODE_WIDTH-1:0] mode_of(logic [TSS_PIN_COUNT-1:0] strap);
        return strap[TSS_MODE_WIDTH-1:0];
    endfunction

    function automatic logic is_driving(tss_state_e state);
        return state == TSS_ST_DRIVE;
    endfunction

    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        tss_state_e state;
        logic por_prev;
        logic [TSS_CNT_WIDTH-1:0] count;
        logic [TSS_PIN_COUNT-1:0] strap;
        logic [TSS_PIN_COUNT-1:0] out_data;
        logic start;
    } tss_regs_s;

    localparam logic [TSS_CNT_WIDTH-1:0] LAST_COUNT =
        TSS_CNT_WIDTH'(SAMPLE_CYCLES - 1);
    localparam tss_regs_s RESET_REGS = '{
        state: TSS_ST_HOLD,
        por_prev: 1'b0,
        count: TSS_CNT_RESET,
        strap: TSS_PINS_LOW,
        out_data: TSS_PINS_LOW,
        start: 1'b0
    };

    tss_regs_s r;
    tss_regs_s next_r;
    logic [TSS_PIN_COUNT-1:0] pad_level;
    logic [TSS_PIN_COUNT-1:0] pin_drive;

    // ************************************************************
    // pin cells
    // ************************************************************
    assign pin_drive = is_driving(r.state) ? TSS_PINS_HIGH : TSS_PINS_LOW;

    for (genvar g = 0; g < TSS_PIN_COUNT; g++) begin : g_pin
        tss_pin_cell u_cell (
            .i_pad(i_test_strap_pin[g]),
            .i_pad_driven(i_test_strap_pin_driven[g]),
            .i_drive(pin_drive[g]),
            .i_out(r.out_data[g]),
            .o_level(pad_level[g]),
            .o_oe(o_test_strap_pin_oe[g]),
            .o_data(o_test_strap_pin[g])
        );
    end

    // ************************************************************
    // sequencing
    // ************************************************************
    always_comb begin
        next_r = r;
        next_r.por_prev = i_power_on_reset_low;
        next_r.start = 1'b0;
        next_r.out_data = i_test_out;
        if (!i_power_on_reset_low) begin
            // pins float and the sequence rewinds while reset is low
            next_r.state = TSS_ST_HOLD;
            next_r.count = TSS_CNT_RESET;
        end else begin
            unique case (r.state)
                TSS_ST_HOLD: begin
                    // a low por_prev starts configuration: a low-to-high edge, or a high reset pin just after i_srst
                    if (!r.por_prev) begin
                        next_r.state = TSS_ST_WAIT;
                        next_r.start = 1'b1;
                        next_r.count = TSS_CNT_RESET;
                    end
                end
                TSS_ST_WAIT: begin
                    if (r.count == LAST_COUNT) begin
                        next_r.strap = pad_level;
                        next_r.state = TSS_ST_DRIVE;
                    end else begin
                        next_r.count = r.count + 1'b1;
                    end
                end
                TSS_ST_DRIVE: begin
                    // strap stays frozen, also while reset is low, until the next capture or i_srst
                    next_r.state = TSS_ST_DRIVE;
                end
                default: begin
                    // an illegal state code falls back to waiting for reset
                    next_r.state = TSS_ST_HOLD;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            r <= RESET_REGS;
        end else begin
            r <= next_r;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign o_test_mode_select = mode_of(r.strap);
    assign o_test_mode_active = (mode_of(r.strap) != TSS_MODE_NORMAL);
    assign o_config_start = r.start;
    assign o_strap_done = is_driving(r.state);
endmodule // tss_strap_sampler

/* File: include/tss_pkg.sv */
// constants and types shared by the test strap sampler
package tss_pkg;
    // ************************************************************
    // sizes and timing
    // ************************************************************
    localparam int unsigned TSS_PIN_COUNT = 8;
    localparam int unsigned TSS_MODE_WIDTH = 3;
    localparam int unsigned TSS_CLK_HZ = 50_000_000;
    // strap sample delay after reset release, in nanoseconds
    localparam int unsigned TSS_SAMPLE_DELAY_NS = 1500;
    localparam int unsigned TSS_SAMPLE_CYCLES =
        (TSS_SAMPLE_DELAY_NS * (TSS_CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int unsigned TSS_CNT_WIDTH = 8;
    localparam logic [TSS_CNT_WIDTH-1:0] TSS_CNT_RESET = 8'h00;
    localparam logic [TSS_MODE_WIDTH-1:0] TSS_MODE_NORMAL = 3'h0;
    localparam logic [TSS_PIN_COUNT-1:0] TSS_PINS_LOW = 8'h00;
    localparam logic [TSS_PIN_COUNT-1:0] TSS_PINS_HIGH = 8'hFF;

    // ************************************************************
    // state machine
    // ************************************************************
    typedef enum logic [2:0] {
        TSS_ST_HOLD = 3'b001,
        TSS_ST_WAIT = 3'b010,
        TSS_ST_DRIVE = 3'b100
    } tss_state_e;
endpackage

/* File: rtl/tss_pin_cell.sv */
// one test pin cell: weak pull-down model and output enable
`timescale 1ns/100ps
module tss_pin_cell (
    // pad side
    input wire logic i_pad,
    input wire logic i_pad_driven,
    // core side
    input wire logic i_drive,
    input wire logic i_out,
    output logic o_level,
    output logic o_oe,
    output logic o_data
);
    // ************************************************************
    // pad logic
    // ************************************************************
    // an undriven pad resolves low through the weak pull-down
    assign o_level = i_pad_driven ? i_pad : 1'b0;
    assign o_oe = i_drive;
    assign o_data = i_drive ? i_out : 1'b0;
endmodule // tss_pin_cell

/* File: testbench/tss_strap_checker.sv */
// assertions on the test strap sampler ports
`timescale 1ns/100ps
module tss_strap_checker #(parameter int unsigned SAMPLE_CYCLES = 4) (
    input wire logic i_clk, i_srst, i_power_on_reset_low,
    input wire logic [7:0] i_test_strap_pin, i_test_strap_pin_driven, i_test_out,
    input wire logic [7:0] o_test_strap_pin, o_test_strap_pin_oe,
    input wire logic [2:0] o_test_mode_select,
    input wire logic o_test_mode_active, o_config_start, o_strap_done
);
    localparam int SM1 = SAMPLE_CYCLES - 1;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_srst);
    property p_tri; !i_power_on_reset_low |=> o_test_strap_pin_oe == 8'h00; endproperty
    a_tri: assert property (p_tri) else $error("pins driven in reset");
    property p_start; $rose(i_power_on_reset_low) |=> o_config_start; endproperty
    a_start: assert property (p_start) else $error("no start pulse");
    property p_pulse; o_config_start |=> !o_config_start; endproperty
    a_pulse: assert property (p_pulse) else $error("start too long");
    // a falling power-on reset aborts the wait, so it cancels the attempt
    property p_done; disable iff (i_srst || !i_power_on_reset_low)
        $rose(o_config_start) |-> ##SM1 !o_strap_done ##1 o_strap_done; endproperty
    a_done: assert property (p_done) else $error("capture time wrong");
    property p_oe; o_test_strap_pin_oe == {8{o_strap_done}}; endproperty
    a_oe: assert property (p_oe) else $error("enable mismatch");
    // an open pad may show anything; only the pull-down level may be captured
    property p_sel; $rose(o_strap_done) |-> o_test_mode_select ==
        $past(i_test_strap_pin[2:0] & i_test_strap_pin_driven[2:0]);
    endproperty
    a_sel: assert property (p_sel) else $error("select bits wrong");
    property p_hold; o_strap_done && $past(o_strap_done) |-> $stable(o_test_mode_select);
    endproperty
    a_hold: assert property (p_hold) else $error("select moved");
    property p_act; o_test_mode_active == (o_test_mode_select != 3'h0); endproperty
    a_act: assert property (p_act) else $error("active wrong");
    property p_out; o_strap_done && $past(o_strap_done) |-> o_test_strap_pin == $past(i_test_out);
    endproperty
    a_out: assert property (p_out) else $error("pin data wrong");
endmodule // tss_strap_checker
bind tss_strap_sampler tss_strap_checker #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) u_chk (.i_clk,
    .i_srst, .i_power_on_reset_low, .i_test_strap_pin, .i_test_strap_pin_driven, .i_test_out,
    .o_test_strap_pin, .o_test_strap_pin_oe, .o_test_mode_select, .o_test_mode_active,
    .o_config_start, .o_strap_done);

/* File: testbench/tss_board.sv */
// board model: strap levels, open pins, back-off while device drives
`timescale 1ns/100ps
module tss_board (
    input wire logic [7:0] i_oe, i_dout, i_val, i_drive,
    output logic [7:0] o_pad, o_driven
);
    // the board backs off wherever the device drives, so no contention
    assign o_driven = i_drive & ~i_oe;
    // an open pad shows noise (inverse of the strap value); only the
    // device's weak pull-down may turn it into a low
    assign o_pad = (i_oe & i_dout) | (~i_oe & ~(o_driven ^ i_val));
endmodule // tss_board

/* File: testbench/tss_strap_sampler_test.sv */
// self-checking bench for the test strap sampler
`timescale 1ns/100ps
module tss_strap_sampler_test;
    import tss_pkg::*;
    localparam int unsigned SC = 4;
    logic i_clk = 0, i_srst = 1, por = 0, act, start, done;
    logic [7:0] pad, drv, dout, oe, tout = 8'h00, bval = 8'h00, bdrv = 8'h00;
    logic [2:0] sel;
    int bad_count = 0, num_checks = 0, exp_sel = 0;
    int exp_q[$];
    logic [7:0] nv, nd, exp_out;
    logic [31:0] rs = 98242;
    function automatic logic [31:0] xorshift(logic [31:0] s);
        logic [31:0] v;
        v = s ^ (s << 13);
        v = v ^ (v >> 17);
        v = v ^ (v << 5);
        return v;
    endfunction
    tss_strap_sampler #(.SAMPLE_CYCLES(SC)) dut (.i_clk(i_clk), .i_srst(i_srst),
        .i_power_on_reset_low(por), .i_test_strap_pin(pad), .i_test_strap_pin_driven(drv),
        .o_test_strap_pin(dout), .o_test_strap_pin_oe(oe), .i_test_out(tout),
        .o_test_mode_select(sel), .o_test_mode_active(act), .o_config_start(start),
        .o_strap_done(done));
    tss_board brd (.i_oe(oe), .i_dout(dout), .i_val(bval), .i_drive(bdrv), .o_pad(pad),
        .o_driven(drv));
    initial forever #10 i_clk = ~i_clk;
    task automatic chk(logic [7:0] seen, logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up();
        $display("checks=%0d bad=%0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // step n rising edges; checks then sample on the falling edge so edge updates have landed
    task automatic cyc(int n);
        repeat (n) @(posedge i_clk);
    endtask
    initial begin
        repeat (10) @(posedge i_clk);
        i_srst <= 0;
        for (int k = 0; k < 8; k++) begin
            cyc(1);
            por <= 1;
            cyc(2);
            por <= 0;
            rs = xorshift(rs);
            // zero strap bits float or are held low by the board
            nv = {rs[7:3], 3'(k)};
            nd = {rs[15:11], 3'(k) | rs[2:0]};
            bval <= nv;
            bdrv <= nd;
            exp_q.push_back(int'(nv[2:0] & nd[2:0]));
            cyc(3);
            @(negedge i_clk);
            chk(oe, 8'h00);
            chk(8'(sel), 8'(exp_sel));
            cyc(1);
            por <= 1;
            cyc(1);
            @(negedge i_clk);
            chk(8'(start), 8'h01);
            cyc(SC - 1);
            @(negedge i_clk);
            chk(8'(done), 8'h00);
            cyc(1);
            exp_out = rs[23:16];
            tout <= exp_out;
            exp_sel = exp_q.pop_front();
            @(negedge i_clk);
            chk(8'(done), 8'h01);
            chk(oe, 8'hFF);
            chk(8'(sel), 8'(exp_sel));
            chk(8'(act), 8'(exp_sel != 0));
            cyc(1);
            @(negedge i_clk);
            chk(pad, exp_out);
        end
        // system reset in mid-run clears the strap; a high reset pin restarts it
        cyc(1);
        i_srst <= 1;
        cyc(2);
        i_srst <= 0;
        @(negedge i_clk);
        chk(oe, 8'h00);
        chk(8'(sel), 8'h00);
        chk(8'(done), 8'h00);
        cyc(1);
        @(negedge i_clk);
        chk(8'(start), 8'h01);
        cyc(SC);
        @(negedge i_clk);
        chk(8'(done), 8'h01);
        chk(8'(sel), 8'(exp_sel));
        wrap_up();
    end
    initial begin
        #100000;
        bad_count++;
        wrap_up();
    end
endmodule // tss_strap_sampler_test
